// *** design/smc_params.svh ***
/*
 * Offsets, field positions, reset values and timing counts of the
 * standby mode control block. Assumes byte addressing, one word each.
 */
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH

`define SMC_ADDR_W 8
`define SMC_OFF_PWC 8'h00
`define SMC_OFF_SVS 8'h04
`define SMC_OFF_OSS 8'h08
`define SMC_OFF_PROT 8'h0c
`define SMC_OFF_BITOP 8'h10
`define SMC_OFF_STATUS 8'h14

`define SMC_PWC_RST 8'h00
`define SMC_SVS_RST 8'h00
`define SMC_OSS_RST 8'h06
`define SMC_PWC_MASK 8'h12
`define SMC_SVS_MASK 8'h01

`define SMC_PWC_REQ_BIT 1
`define SMC_PWC_WBLK_BIT 4
`define SMC_SVS_DEPTH_BIT 0

`define SMC_PROT_KEY 8'ha5

`define SMC_BITOP_IDX_LSB 0
`define SMC_BITOP_VAL_BIT 3
`define SMC_BITOP_TGT_LSB 4

`define SMC_ST_ARMED_BIT 0
`define SMC_ST_ERR_BIT 1
`define SMC_ST_STANDBY_BIT 2
`define SMC_ST_SETTLE_BIT 3

`define SMC_SETTLE_BASE 16

`endif

// *** design/smc_pkg.sv ***
/*
 * Types of the standby mode control block.
 * Assumes smc_params.svh sits beside it for the numeric constants.
 */
package smc_pkg;
  typedef enum logic [1:0] {
    SMC_RUN,
    SMC_IDLE,
    SMC_STOP,
    SMC_SETTLE
  } smc_state_t;

  typedef enum logic [1:0] {
    SMC_TGT_PWC,
    SMC_TGT_SVS,
    SMC_TGT_OSS,
    SMC_TGT_NONE
  } smc_tgt_t;
endpackage

// *** design/smc_top.sv ***
/*
 * Standby mode control: control, variant and settle-select registers
 * behind an Avalon-MM slave, plus the standby state machine.
 * Assumes a single 100 MHz clock, synchronous wake inputs and a
 * clock generator that obeys the stop and settle outputs.
 */
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"

// Functional notes
// - Control register changes only when a write follows the protect key; hardware also clears the request bit on release from standby.
// - Control register accessible as whole byte or single bit.
// - Control register resets to zero: normal mode, interrupt wake on.
// - Eight-bit standby variant register governs behaviour in standby.
// - Variant register byte or bit access, resets to zero (idle).
// - Stop exit by interrupt waits the selected settle interval.
// - Settle select register byte access only; bit operations refused.
// - Settle select register resets to six.
module smc_top
  import smc_pkg::*;
#(
  parameter int SETTLE_BASE = `SMC_SETTLE_BASE
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [`SMC_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Wake sources
  input wire logic maskable_interrupt_request_i,
  input wire logic nonmaskable_wake_i,
  // Clock generator control
  output logic cpu_clock_stop_o,
  output logic osc_stop_o,
  output logic settle_busy_o
);

  logic [7:0] pwc_q, pwc_d;
  logic [7:0] svs_q, svs_d;
  logic [7:0] oss_q, oss_d;
  logic armed_q, armed_d;
  logic err_q, err_d;
  logic wait_q;
  logic [31:0] rdata_q;
  smc_state_t st_q, st_d;
  // Wide enough for any shift of the base
  logic [31:0] cnt_q, cnt_d;
  logic cpu_stop_q, osc_stop_q, settle_q;

  function automatic logic [7:0] bit_apply(input logic [7:0] v,
      input logic [2:0] idx, input logic val);
    logic [7:0] r;
    r = v;
    r[idx] = val;
    return r;
  endfunction

  // Bus decode
  wire logic req = avs_read_i | avs_write_i;
  wire logic acc = req & ~wait_q;
  wire logic wr = acc & avs_write_i & avs_byteenable_i[0];
  // Only the low byte lane carries register data
  wire logic [7:0] wb = avs_writedata_i[7:0];
  wire logic hit_pwc = avs_address_i == `SMC_OFF_PWC;
  wire logic hit_svs = avs_address_i == `SMC_OFF_SVS;
  wire logic hit_oss = avs_address_i == `SMC_OFF_OSS;
  wire logic hit_prot = avs_address_i == `SMC_OFF_PROT;
  wire logic hit_bit = avs_address_i == `SMC_OFF_BITOP;
  wire logic hit_st = avs_address_i == `SMC_OFF_STATUS;
  wire logic [2:0] b_idx = wb[`SMC_BITOP_IDX_LSB +: 3];
  wire logic b_val = wb[`SMC_BITOP_VAL_BIT];
  wire smc_tgt_t b_tgt = smc_tgt_t'(wb[`SMC_BITOP_TGT_LSB +: 2]);
  wire logic bit_op = wr & hit_bit;
  wire logic pwc_try = (wr & hit_pwc) | (bit_op & b_tgt == SMC_TGT_PWC);
  wire logic pwc_ok = pwc_try & armed_q;
  wire logic [7:0] pwc_new = hit_pwc ? wb
      : bit_apply(pwc_q, b_idx, b_val);

  // Wake qualification
  wire logic wake_mask = maskable_interrupt_request_i
      & ~pwc_q[`SMC_PWC_WBLK_BIT];
  wire logic wake = wake_mask | nonmaskable_wake_i;
  // Settle select encoding is open: the base doubles per step
  wire logic [31:0] settle_len =
      32'(SETTLE_BASE) << oss_q[2:0];

  // Status is read-only apart from the sticky error
  wire logic [7:0] status = {4'h0, st_q == SMC_SETTLE,
      st_q != SMC_RUN, err_q, armed_q};
  wire logic [7:0] rsel = hit_pwc ? pwc_q : hit_svs ? svs_q
      : hit_oss ? oss_q : hit_st ? status : 8'h00;

  // Register next values
  always_comb begin
    pwc_d = pwc_q;
    svs_d = svs_q;
    oss_d = oss_q;
    armed_d = armed_q;
    err_d = err_q;
    if (pwc_ok) begin
      pwc_d = pwc_new & `SMC_PWC_MASK;
    end
    if (wr & hit_svs) begin
      svs_d = wb & `SMC_SVS_MASK;
    end else if (bit_op & b_tgt == SMC_TGT_SVS) begin
      svs_d = bit_apply(svs_q, b_idx, b_val) & `SMC_SVS_MASK;
    end
    if (wr & hit_oss) begin
      oss_d = wb;
    end
    if (wr & hit_st & wb[`SMC_ST_ERR_BIT]) begin
      err_d = 1'b0;
    end
    // A new error beats a clear in the same cycle
    if (pwc_try & ~armed_q) begin
      err_d = 1'b1;
    end
    if (bit_op & b_tgt == SMC_TGT_OSS) begin
      err_d = 1'b1;
    end
    // Any other write disarms, so a stray store cannot land later
    if (acc & avs_write_i) begin
      armed_d = hit_prot & avs_byteenable_i[0] & wb == `SMC_PROT_KEY;
    end
    // Release by hardware clears the request
    if (st_q != SMC_RUN && st_d == SMC_RUN ||
        st_q == SMC_STOP && st_d == SMC_SETTLE) begin
      pwc_d[`SMC_PWC_REQ_BIT] = 1'b0;
    end
  end

  // Standby sequencing
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      SMC_RUN: begin
        if (pwc_q[`SMC_PWC_REQ_BIT]) begin
          st_d = svs_q[`SMC_SVS_DEPTH_BIT] ? SMC_STOP : SMC_IDLE;
        end
      end
      SMC_IDLE: begin
        if (wake) begin
          st_d = SMC_RUN;
        end
      end
      SMC_STOP: begin
        if (wake) begin
          st_d = SMC_SETTLE;
          cnt_d = settle_len;
        end
      end
      SMC_SETTLE: begin
        if (cnt_q <= 32'd1) begin
          st_d = SMC_RUN;
          cnt_d = 32'd0;
        end else begin
          cnt_d = cnt_q - 32'd1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwc_q <= `SMC_PWC_RST;
      svs_q <= `SMC_SVS_RST;
      oss_q <= `SMC_OSS_RST;
      armed_q <= 1'b0;
      err_q <= 1'b0;
      st_q <= SMC_RUN;
      cnt_q <= 32'd0;
    end else begin
      pwc_q <= pwc_d;
      svs_q <= svs_d;
      oss_q <= oss_d;
      armed_q <= armed_d;
      err_q <= err_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // One idle cycle, then the answer; read data taken with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~(req & wait_q);
      rdata_q <= {24'h00_0000, rsel};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_stop_q <= 1'b0;
      osc_stop_q <= 1'b0;
      settle_q <= 1'b0;
    end else begin
      cpu_stop_q <= st_d != SMC_RUN;
      osc_stop_q <= st_d == SMC_STOP;
      settle_q <= st_d == SMC_SETTLE;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign cpu_clock_stop_o = cpu_stop_q;
  assign osc_stop_o = osc_stop_q;
  assign settle_busy_o = settle_q;

endmodule
`default_nettype wire

// *** tb/smc_props.sv ***
/* Port checker of smc_top.
   Assumes it is bound to smc_top and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"
module smc_props #(parameter int SETTLE_BASE = 16) (
  // Bus side
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`SMC_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Wake and clock control
  input wire logic maskable_interrupt_request_i,
  input wire logic nonmaskable_wake_i,
  input wire logic cpu_clock_stop_o,
  input wire logic osc_stop_o,
  input wire logic settle_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_wait_once: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
  chk_wait_pulse: assert property (!avs_waitrequest_o |=>
    avs_waitrequest_o) else $error("wait low too long");
  chk_rdata_byte: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_osc_cpu: assert property (osc_stop_o |-> cpu_clock_stop_o)
    else $error("stop without cpu halt");
  chk_settle_cpu: assert property (settle_busy_o |->
    cpu_clock_stop_o && !osc_stop_o) else $error("settle outputs");
  chk_settle_origin: assert property ($rose(settle_busy_o) |->
    $past(osc_stop_o)) else $error("settle not from stop");
  chk_stop_exit: assert property ($fell(osc_stop_o) |->
    settle_busy_o) else $error("stop left without settle");
  chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
    avs_waitrequest_o && !cpu_clock_stop_o && !osc_stop_o &&
    !settle_busy_o) else $error("reset outputs");
endmodule
bind smc_top smc_props #(.SETTLE_BASE(SETTLE_BASE)) i_props (.clk_i,
  .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
  .maskable_interrupt_request_i, .nonmaskable_wake_i, .cpu_clock_stop_o,
  .osc_stop_o, .settle_busy_o);
`default_nettype wire

// *** tb/standby_mode_control_tb_top.sv ***
/* Bench of smc_top: registers, protection and standby.
   Assumes the design answers each access; only the watchdog ends a wait. */
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"
module standby_mode_control_tb_top;
  localparam int SB = 2;
  localparam logic [7:0] PWC = `SMC_OFF_PWC, SVS = `SMC_OFF_SVS;
  localparam logic [7:0] ST = `SMC_OFF_STATUS;
  localparam logic [7:0] ARMB = 8'h01 << `SMC_ST_ARMED_BIT;
  localparam logic [7:0] ERRB = 8'h01 << `SMC_ST_ERR_BIT;
  localparam logic [7:0] SBYB = 8'h01 << `SMC_ST_STANDBY_BIT;
  localparam logic [7:0] OSS = `SMC_OFF_OSS, KA = `SMC_OFF_PROT;
  localparam logic [7:0] BOP = `SMC_OFF_BITOP, KEY = `SMC_PROT_KEY;
  logic clk_i = 0, rst_i = 1, rd = 0, wr = 0, mi = 0, nmi = 0;
  logic ws, cs, os, sb;
  logic [3:0] be = 4'hf;
  logic [7:0] a = 0, sel;
  logic [31:0] wd = 0, q, rdat;
  int errors = 0, compares = 0, seed = 32'hba63, n;
  always #5 clk_i = ~clk_i;
  smc_top #(.SETTLE_BASE(SB)) i_dut (.clk_i, .rst_i, .avs_address_i(a),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(ws), .maskable_interrupt_request_i(mi),
    .nonmaskable_wake_i(nmi), .cpu_clock_stop_o(cs), .osc_stop_o(os),
    .settle_busy_o(sb));
  task chk(input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %0t %h vs %h", $time, s, e);
    end
  endtask
  // Upper data bits random: the block must ignore them
  task acc(input logic w, input logic [7:0] ad, d);
    wr <= w;
    rd <= !w;
    a <= ad;
    wd <= ($random(seed) << 8) | d;
    while (ws !== 1'b0) @(posedge clk_i);
    q = rdat;
    wr <= 0;
    rd <= 0;
    @(posedge clk_i);
  endtask
  task rc(input logic [7:0] ad, input logic [31:0] e);
    acc(0, ad, 0);
    chk(q, e);
  endtask
  task report_and_stop;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #60000;
    errors++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    rc(PWC, `SMC_PWC_RST);
    rc(SVS, `SMC_SVS_RST);
    rc(OSS, `SMC_OSS_RST);
    rc(8'h40, 0);
    acc(1, PWC, 8'h12);
    rc(PWC, 0);
    acc(0, ST, 0);
    chk(q[1], 1);
    acc(1, KA, KEY);
    rc(ST, ERRB | ARMB);
    acc(1, PWC, 8'hfd);
    rc(PWC, `SMC_PWC_MASK & 8'hfd);
    acc(1, KA, KEY);
    acc(1, BOP, 8'h04);
    rc(PWC, 0);
    acc(1, SVS, 8'hff);
    rc(SVS, 1);
    acc(1, BOP, 8'h10);
    rc(SVS, 0);
    sel = $random(seed);
    acc(1, OSS, sel);
    rc(OSS, sel);
    acc(1, ST, ERRB);
    rc(ST, 0);
    acc(1, BOP, {4'h2, !sel[1], 3'd1});
    rc(OSS, sel);
    rc(ST, ERRB);
    acc(1, SVS, 1);
    be <= 4'he;
    acc(1, SVS, 0);
    be <= 4'hf;
    rc(SVS, 1);
    acc(1, KA, KEY);
    acc(1, PWC, 8'h12);
    mi <= 1;
    repeat (8) @(posedge clk_i);
    chk({cs, os}, 2'b11);
    nmi <= 1;
    n = 0;
    repeat (600) begin
      @(posedge clk_i);
      nmi <= 0;
      n += sb;
    end
    chk(n, SB << sel[2:0]);
    rc(PWC, 8'h10);
    mi <= 0;
    acc(1, SVS, 0);
    acc(1, KA, KEY);
    acc(1, PWC, 8'h02);
    repeat (8) @(posedge clk_i);
    chk({cs, os}, 2'b10);
    rc(ST, ERRB | SBYB);
    mi <= 1;
    repeat (8) @(posedge clk_i);
    chk(cs, 0);
    rc(PWC, 0);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    rc(OSS, `SMC_OSS_RST);
    rc(ST, 0);
    report_and_stop;
  end
endmodule
`default_nettype wire
